/* File: pkg/sram_host_pkg.sv */
// Constants, state codes and timing counts for the asynchronous SRAM host.
// Assumes a single 10 MHz system clock; all pin timing is met in whole cycles.
package sram_host_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and bus shape
    localparam int CLK_PERIOD_NS = 100;  // 10 MHz system clock
    localparam int ADDR_W = 21;          // 2M words
    localparam int DATA_W = 16;          // Two byte lanes
    localparam int SYNC_STAGES = 2;      // Data-in synchroniser depth

    ////////////////////////////////////////////////////////////////////////////
    // Pin timing in ns, slow grade taken so both grades are covered
    localparam int T_RC_NS = 12;   // Read cycle, least
    localparam int T_AA_NS = 12;   // Address access, longest
    localparam int T_HZ_NS = 6;    // Float after release, longest
    localparam int T_WC_NS = 12;   // Write cycle, least
    localparam int T_WP_NS = 9;    // Write pulse with output gate high, least
    localparam int T_DW_NS = 7;    // Data setup before end of write, least

    // Least times round up to whole cycles, never under one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RC_CYC = ns_to_cyc(T_RC_NS);
    localparam int AA_CYC = ns_to_cyc(T_AA_NS);
    localparam int HZ_CYC = ns_to_cyc(T_HZ_NS);
    localparam int WC_CYC = ns_to_cyc(T_WC_NS);
    localparam int WP_CYC = ns_to_cyc(T_WP_NS);
    localparam int DW_CYC = ns_to_cyc(T_DW_NS);
    // Strobe low long enough for both pulse width and data setup
    localparam int WR_LOW_CYC = (WP_CYC > DW_CYC) ? WP_CYC : DW_CYC;
    // Read strobes held through access plus the input synchroniser
    localparam int RD_HOLD_CYC = ((AA_CYC > RC_CYC) ? AA_CYC : RC_CYC) + SYNC_STAGES;

    ////////////////////////////////////////////////////////////////////////////
    // Controller states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_RD_ACT   = 6'h02,
        ST_TURN     = 6'h04,
        ST_WR_SETUP = 6'h08,
        ST_WR_PULSE = 6'h10,
        ST_WR_END   = 6'h20
    } ctrl_state_type;

    // Idle pin levels
    localparam logic PIN_INACTIVE = 1'b1;  // All strobes active low

endpackage

/* File: hw/pin_sync2.sv */
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the bus is quiet while sampled, as a held SRAM read word is.
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Pin side
    input wire logic [W-1:0] d,
    // Logic side
    output logic [W-1:0] q
);

    // Both stages in one record; the first is read by the second only
    typedef struct packed {
        logic [W-1:0] meta;  // First stage, may go metastable
        logic [W-1:0] q;  // Second stage, safe to use
    } sync_type;

    // Current and next stages
    sync_type st_ff;
    sync_type nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // Shift one stage per clock
    always_comb begin
        nxt_st.meta = d;
        nxt_st.q = st_ff.meta;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Both stages clear on reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;

endmodule

/* File: hw/sram_host_ctrl.sv */
// Host controller driving an asynchronous 2M x 16 static memory by its pins.
// Assumes one request at a time from user logic on clk_sys, and that the
// testbench resolves the shared data wire from sram_dq_oe.
`timescale 1ns/1ps
module sram_host_ctrl #(
    parameter int ADDR_W = sram_host_pkg::ADDR_W,
    parameter int DATA_W = sram_host_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_be,
    // User answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Memory control pins
    output logic [ADDR_W-1:0] sram_addr,
    output logic sram_cs_n,
    output logic sram_we_n,
    output logic sram_oe_n,
    output logic low_byte_sel_n,
    output logic high_byte_sel_n,
    // Memory data pins, split into three signals
    input wire logic [DATA_W-1:0] sram_dq_in,
    output logic [DATA_W-1:0] sram_dq_out,
    output logic sram_dq_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // All controller state in one record
    typedef struct packed {
        sram_host_pkg::ctrl_state_type state;  // Sequencer
        logic [3:0] cnt;                       // Cycles left in a phase
        logic req_ready;                       // Accepting a request
        logic rsp_valid;                       // Answer pulse
        logic is_write;                        // Kind of current access
        logic [DATA_W-1:0] rdata;              // Captured read word
        logic [ADDR_W-1:0] addr;               // Address pins
        logic cs_n;                            // Chip select pin
        logic we_n;                            // Write strobe pin
        logic oe_n;                            // Output gate pin
        logic lo_lane_n;                       // Low lane pin
        logic hb_n;                            // High lane pin
        logic [DATA_W-1:0] dq_out;             // Write data
        logic dq_oe;                           // Data bus drive enable
    } ctrl_type;

    // Current and next state
    ctrl_type st_ff;
    ctrl_type nxt_st;
    // Read data after two flops
    logic [DATA_W-1:0] dq_sync;

    // Request taken this cycle
    logic take;
    assign take = req_valid && st_ff.req_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Data-in synchroniser; the pins are asynchronous to clk_sys
    pin_sync2 #(
        .W(DATA_W)
    ) u_dq_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d(sram_dq_in),
        .q(dq_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reset value: deselected, strobes high, bus floating, ready
    function automatic ctrl_type idle_value();
        ctrl_type v;
        v = '0;
        v.state = sram_host_pkg::ST_IDLE;
        v.req_ready = 1'b1;
        v.cs_n = sram_host_pkg::PIN_INACTIVE;
        v.we_n = sram_host_pkg::PIN_INACTIVE;
        v.oe_n = sram_host_pkg::PIN_INACTIVE;
        v.lo_lane_n = sram_host_pkg::PIN_INACTIVE;
        v.hb_n = sram_host_pkg::PIN_INACTIVE;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp_valid = 1'b0;
        unique case (st_ff.state)
            sram_host_pkg::ST_IDLE: begin
                if (take) begin
                    // Address, lanes and select set while the write strobe is still high
                    nxt_st.req_ready = 1'b0;
                    nxt_st.is_write = req_write;
                    nxt_st.addr = req_addr;
                    nxt_st.lo_lane_n = ~req_be[0];
                    nxt_st.hb_n = ~req_be[1];
                    nxt_st.cs_n = 1'b0;
                    nxt_st.we_n = 1'b1;
                    if (req_write) begin
                        // Output gate kept high so the shorter pulse applies
                        nxt_st.oe_n = 1'b1;
                        nxt_st.dq_out = req_wdata;
                        // Memory floated: gate high since the last turnaround
                        nxt_st.dq_oe = 1'b1;
                        nxt_st.state = sram_host_pkg::ST_WR_SETUP;
                    end else begin
                        nxt_st.oe_n = 1'b0;
                        nxt_st.dq_oe = 1'b0;
                        nxt_st.cnt = 4'(sram_host_pkg::RD_HOLD_CYC - 1);
                        nxt_st.state = sram_host_pkg::ST_RD_ACT;
                    end
                end
            end
            sram_host_pkg::ST_RD_ACT: begin
                // Pins held; address stays put for the whole read
                if (st_ff.cnt == 4'h0) begin
                    nxt_st.rdata = dq_sync;
                    nxt_st.rsp_valid = 1'b1;
                    nxt_st.cs_n = 1'b1;
                    nxt_st.oe_n = 1'b1;
                    nxt_st.lo_lane_n = 1'b1;
                    nxt_st.hb_n = 1'b1;
                    // Wait out the memory's float time before any drive
                    nxt_st.cnt = 4'(sram_host_pkg::HZ_CYC - 1);
                    nxt_st.state = sram_host_pkg::ST_TURN;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end
            end
            sram_host_pkg::ST_WR_SETUP: begin
                // Address, select, lanes and data stood one cycle already
                nxt_st.we_n = 1'b0;
                nxt_st.cnt = 4'(sram_host_pkg::WR_LOW_CYC - 1);
                nxt_st.state = sram_host_pkg::ST_WR_PULSE;
            end
            sram_host_pkg::ST_WR_PULSE: begin
                if (st_ff.cnt == 4'h0) begin
                    // End of write by strobe and select together
                    nxt_st.we_n = 1'b1;
                    nxt_st.cs_n = 1'b1;
                    nxt_st.state = sram_host_pkg::ST_WR_END;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end
            end
            sram_host_pkg::ST_WR_END: begin
                // Address, data and lanes held past the end of write
                nxt_st.dq_oe = 1'b0;
                nxt_st.lo_lane_n = 1'b1;
                nxt_st.hb_n = 1'b1;
                nxt_st.rsp_valid = 1'b1;
                nxt_st.req_ready = 1'b1;
                nxt_st.state = sram_host_pkg::ST_IDLE;
            end
            sram_host_pkg::ST_TURN: begin
                if (st_ff.cnt == 4'h0) begin
                    nxt_st.req_ready = 1'b1;
                    nxt_st.state = sram_host_pkg::ST_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end
            end
            default: begin
                // Illegal code: back to a safe idle
                nxt_st = idle_value();
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_ff <= idle_value();
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from state flops
    assign req_ready = st_ff.req_ready;
    assign rsp_valid = st_ff.rsp_valid;
    assign rsp_rdata = st_ff.rdata;
    assign sram_addr = st_ff.addr;
    assign sram_cs_n = st_ff.cs_n;
    assign sram_we_n = st_ff.we_n;
    assign sram_oe_n = st_ff.oe_n;
    assign low_byte_sel_n = st_ff.lo_lane_n;
    assign high_byte_sel_n = st_ff.hb_n;
    assign sram_dq_out = st_ff.dq_out;
    assign sram_dq_oe = st_ff.dq_oe;

endmodule

/* File: tb/sram_host_ctrl_properties.sv */
// Pin protocol checker for the SRAM host controller.
// Assumes it is bound into sram_host_ctrl; one clock domain.
`timescale 1ns/1ps
module sram_host_chk #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Memory pins
    input wire logic [ADDR_W-1:0] sram_addr,
    input wire logic sram_cs_n,
    input wire logic sram_we_n,
    input wire logic sram_oe_n,
    input wire logic low_byte_sel_n,
    input wire logic high_byte_sel_n,
    input wire logic [DATA_W-1:0] sram_dq_out,
    input wire logic sram_dq_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    AST_WE_HIGH_READ: assert property (!sram_oe_n |-> sram_we_n)
        else $error("write strobe low while output gate on");
    // Three held cycles cover access time plus the input synchroniser
    AST_READ_LEN: assert property ($fell(sram_oe_n) |-> (!sram_cs_n && !sram_oe_n) [*3] ##1 sram_oe_n)
        else $error("read strobes not held three cycles");
    AST_WRITE_SEL: assert property (!sram_we_n |-> !sram_cs_n)
        else $error("write strobe without select");
    AST_OE_HIGH_WRITE: assert property (!sram_we_n |-> sram_oe_n)
        else $error("output gate low in write pulse");
    AST_SEL_BEFORE: assert property ($fell(sram_we_n) |-> $past(sram_cs_n) == 1'b0)
        else $error("select not active before write pulse");
    AST_ADDR_HELD: assert property (!sram_we_n |-> $stable(sram_addr))
        else $error("address moved during write");
    AST_LANES_HELD: assert property (!sram_we_n |-> $stable({low_byte_sel_n, high_byte_sel_n}))
        else $error("lane selects moved during write");
    AST_DATA_SETUP: assert property (!sram_we_n |-> sram_dq_oe && $stable(sram_dq_out))
        else $error("write data not set up");
    AST_NO_CONTENTION: assert property (!sram_cs_n && !sram_oe_n |-> !sram_dq_oe)
        else $error("host drives bus during read");
    // Main scenarios
    cover property ($fell(sram_oe_n));
    cover property ($fell(sram_we_n) && !low_byte_sel_n && high_byte_sel_n);
    cover property ($fell(sram_we_n) && !low_byte_sel_n && !high_byte_sel_n);
endmodule

bind sram_host_ctrl sram_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
    .clk_sys(clk_sys), .resetn(resetn), .sram_addr(sram_addr),
    .sram_cs_n(sram_cs_n), .sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n),
    .low_byte_sel_n(low_byte_sel_n), .high_byte_sel_n(high_byte_sel_n),
    .sram_dq_out(sram_dq_out), .sram_dq_oe(sram_dq_oe)
);

/* File: tb/sram_mem_model.sv */
// Behavioural model of the asynchronous x16 static memory.
// Assumes the host's data drive is fed in; resolves the shared wire.
`timescale 1ns/1ps
module sram_mem_model #(
    parameter int ACC_NS = 12  // Access time, slow grade
) (
    // Control pins
    input wire logic [20:0] addr,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic low_byte_sel_n,
    input wire logic high_byte_sel_n,
    // Host drive in, resolved wire out
    input wire logic [15:0] host_dq,
    input wire logic host_oe,
    output logic [15:0] dq
);
    logic [15:0] mem [int];  // Sparse word store
    logic [15:0] rd_word;  // Word after access delay
    logic [15:0] float_pat = 16'ha5a5;  // Undriven lines change each cycle
    logic rd_on;  // Outputs driven
    always #100 float_pat = ~float_pat;
    // Write during overlap of select, strobe and lane
    always @* begin
        if (!cs_n && !we_n) begin
            if (!low_byte_sel_n) mem[addr][7:0] = host_dq[7:0];
            if (!high_byte_sel_n) mem[addr][15:8] = host_dq[15:8];
        end
    end
    // Old word stays until the access delay runs out
    // Explicit events: a whole store in the sensitivity list would crawl; we_n rising marks new data
    always @(addr or cs_n or we_n) rd_word <= #(ACC_NS) (mem.exists(addr) ? mem[addr] : float_pat);
    assign rd_on = !cs_n && !oe_n && we_n;
    assign dq[7:0] = host_oe ? host_dq[7:0] : (rd_on && !low_byte_sel_n) ? rd_word[7:0] : float_pat[7:0];
    assign dq[15:8] = host_oe ? host_dq[15:8] : (rd_on && !high_byte_sel_n) ? rd_word[15:8] : float_pat[15:8];
endmodule

/* File: tb/sram_host_ctrl_tb.sv */
// Self-checking bench for the SRAM host controller.
// Assumes the memory model resolves the shared data wire.
`timescale 1ns/1ps
module sram_host_ctrl_tb;
    logic clk_sys = 1'b0, resetn = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0;
    logic [20:0] req_addr = 21'h0, sram_addr;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, dq_out, dq_in, rd;
    logic [1:0] req_be = 2'h0;
    logic req_ready, rsp_valid, sram_cs_n, sram_we_n, sram_oe_n, lo_lane_n, hb_n, dq_oe;
    int n_errors = 0, n_checks = 0;
    always #50 clk_sys = ~clk_sys;
    sram_host_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_be(req_be), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .sram_addr(sram_addr), .sram_cs_n(sram_cs_n), .sram_we_n(sram_we_n),
        .sram_oe_n(sram_oe_n), .low_byte_sel_n(lo_lane_n), .high_byte_sel_n(hb_n),
        .sram_dq_in(dq_in), .sram_dq_out(dq_out), .sram_dq_oe(dq_oe));
    sram_mem_model #(.ACC_NS(12)) mem_u (.addr(sram_addr), .cs_n(sram_cs_n), .we_n(sram_we_n),
        .oe_n(sram_oe_n), .low_byte_sel_n(lo_lane_n), .high_byte_sel_n(hb_n),
        .host_dq(dq_out), .host_oe(dq_oe), .dq(dq_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One request; answer must come four cycles after the take
    task automatic do_req(input logic w, input logic [20:0] a, input logic [15:0] d,
                          input logic [1:0] be, output logic [15:0] q);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_be = be;
        @(negedge clk_sys);
        req_valid = 1'b0;
        check(16'(req_ready), 16'h0000);
        n = 1;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check(16'(n), 16'h0004);
        check(16'(req_ready), 16'(w));
        q = rsp_rdata;
    endtask
    task automatic t_reset();
        @(negedge clk_sys);
        check(16'({req_ready, sram_cs_n, sram_we_n, sram_oe_n, lo_lane_n, hb_n, dq_oe}), 16'h007e);
        $display("reset test done");
    endtask
    task automatic t_word();
        do_req(1'b1, 21'h000001, 16'h1234, 2'h3, rd);
        do_req(1'b0, 21'h000001, 16'h0000, 2'h3, rd);
        check(rd, 16'h1234);
        $display("word test done");
    endtask
    // Each lane alone, then no lane at all
    task automatic t_lanes();
        do_req(1'b1, 21'h000a00, 16'hffff, 2'h3, rd);
        do_req(1'b1, 21'h000a00, 16'h00c3, 2'h1, rd);
        do_req(1'b1, 21'h000a00, 16'h3c00, 2'h2, rd);
        do_req(1'b1, 21'h000a00, 16'h0000, 2'h0, rd);
        do_req(1'b0, 21'h000a00, 16'h0000, 2'h3, rd);
        check(rd, 16'h3cc3);
        do_req(1'b0, 21'h000a00, 16'h0000, 2'h1, rd);
        check({8'h00, rd[7:0]}, 16'h00c3);
        $display("lane test done");
    endtask
    // Back-to-back at both address extremes
    task automatic t_b2b();
        do_req(1'b1, 21'h1fffff, 16'hbeef, 2'h3, rd);
        do_req(1'b1, 21'h000000, 16'h0f0f, 2'h3, rd);
        do_req(1'b0, 21'h1fffff, 16'h0000, 2'h3, rd);
        check(rd, 16'hbeef);
        do_req(1'b0, 21'h000000, 16'h0000, 2'h3, rd);
        check(rd, 16'h0f0f);
        $display("back to back test done");
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the few dozen cycles needed
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        t_reset();
        t_word();
        t_lanes();
        t_b2b();
        finish_test();
    end
endmodule
